// file: rpc_map.svh
// register offsets, field positions, reset values for the prefetch cache control
`ifndef RPC_MAP_SVH
`define RPC_MAP_SVH
`define RPC_OFF_CFG        8'h00
`define RPC_OFF_THRESH     8'h04
`define RPC_OFF_MINPF      8'h08
`define RPC_OFF_MAXPF      8'h0c
`define RPC_OFF_CEIL       8'h10
`define RPC_OFF_LAST_LBA   8'h14
`define RPC_OFF_STATUS     8'h18
`define RPC_OFF_LIMITS     8'h1c
`define RPC_CFG_SCALE_BIT  0
`define RPC_CFG_RRET_LSB   4
`define RPC_CFG_WRET_LSB   8
`define RPC_CFG_MASK       32'h0000_0ff1
`define RPC_ST_RUN_BIT     0
`define RPC_ST_SKIP_BIT    1
`define RPC_ST_DEFER_BIT   2
`define RPC_RST_CFG        32'h0000_0000
`define RPC_RST_THRESH     16'hffff
`define RPC_RST_MINPF      16'h0000
`define RPC_RST_MAXPF      16'hffff
`define RPC_RST_CEIL       16'hffff
`define RPC_RST_LAST_LBA   32'hffff_ffff
`define RPC_RET_CODE_NONE  4'h0
`define RPC_RET_CODE_SOON  4'h1
`define RPC_RET_CODE_KEEP  4'hf
`define RPC_RESP_OKAY      2'b00
`define RPC_RESP_SLVERR    2'b10
`endif

// file: rpc_pkg.sv
// types shared by the prefetch cache control files
`default_nettype none
package rpc_pkg;
  typedef enum logic [1:0] {
    RPC_IDLE = 2'b01,
    RPC_RUN  = 2'b10
  } rpc_state_t;
  typedef enum logic [1:0] {
    RPC_RET_NONE   = 2'h0,
    RPC_RET_SOONER = 2'h1,
    RPC_RET_KEEP   = 2'h2,
    RPC_RET_RSVD   = 2'h3
  } rpc_ret_t;
endpackage
`default_nettype wire

// file: rpc_scale.sv
// converts a prefetch field into a block count, with optional ceiling
`timescale 1ns/1ps
`default_nettype none
module rpc_scale (
  input  wire logic        scale_mode,
  input  wire logic [15:0] field,
  input  wire logic [15:0] xfer_len,
  input  wire logic [15:0] ceiling,
  input  wire logic        use_ceiling,
  output logic      [31:0] blocks
);
  logic [31:0] raw;

  // scaled mode multiplies by the current transfer length
  always_comb
  begin
    // both factors widened first so the full 32-bit product is kept
    raw = scale_mode ? ({16'h0000, field} * {16'h0000, xfer_len}) : {16'h0000, field}; // R14
    blocks = raw;
    if (use_ceiling && (raw > {16'h0000, ceiling}))
    begin
      blocks = {16'h0000, ceiling}; // R13
    end
  end
endmodule
`default_nettype wire

// file: rpc_retain.sv
// decodes a four-bit retention priority code into a class
`timescale 1ns/1ps
`default_nettype none
`include "rpc_map.svh"
module rpc_retain (
  input  wire logic [3:0]      code,
  output rpc_pkg::rpc_ret_t    ret_class
);
  // codes 2h to eh fall to reserved; the cache treats them as no preference
  always_comb
  begin
    if (code == `RPC_RET_CODE_NONE)
      ret_class = rpc_pkg::RPC_RET_NONE; // R15
    else if (code == `RPC_RET_CODE_SOON)
      ret_class = rpc_pkg::RPC_RET_SOONER; // R15
    else if (code == `RPC_RET_CODE_KEEP)
      ret_class = rpc_pkg::RPC_RET_KEEP; // R15
    else
      ret_class = rpc_pkg::RPC_RET_RSVD;
  end
endmodule
`default_nettype wire

// file: rpc_top.sv
// read prefetch and cache retention control with an axi4-lite register port
// Summary of operation
// R01 - write retention code advises how long written, already flushed data stays cached
// R02 - prefetch decisions follow the most recent read command
// R03 - prefetch settings are hints; never raise a check condition when unmet
// R04 - skip prefetch when read length exceeds threshold, otherwise try one
// R05 - threshold of zero disables all prefetch, zero-length reads included
// R06 - minimum count from field and scale mode is always fetched; here clamped to the maximum and cut short by medium end or a fatal error
// R07 - prefetch starts at block right after the read's final block
// R08 - prefetch always stops before the last block of the medium
// R09 - prefetch errors hidden unless fatal; fatal ones reported as deferred
// R10 - past the minimum count, abandon prefetch once another command is ready
// R11 - no early abandon when minimum and maximum fields are equal
// R12 - maximum count from field and scale mode bounds each read's prefetch
// R13 - maximum count is truncated to the ceiling value
// R14 - scale mode clear means block counts; set means multiply by length
// R15 - retention codes: 0 none, 1h replace sooner, fh keep, others reserved
// R16 - settings are held and applied from the next read command onward
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "rpc_map.svh"
module rpc_top (
  input  wire logic               sys_clk,
  input  wire logic               reset_n,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic               rd_cmd_valid,
  input  wire logic [31:0]        rd_cmd_lba,
  input  wire logic [15:0]        rd_cmd_len,
  input  wire logic               cmd_pending,
  output logic                    pf_req_valid,
  output logic [31:0]             pf_req_lba,
  input  wire logic               pf_req_ready,
  input  wire logic               pf_err,
  input  wire logic               pf_err_fatal,
  output logic                    deferred_err,
  output rpc_pkg::rpc_ret_t       read_ret_class,
  output rpc_pkg::rpc_ret_t       write_ret_class
);
  logic                rst_meta_q;
  logic                rst_n;
  logic [31:0]         cfg_q;
  logic [15:0]         thresh_q;
  logic [15:0]         minpf_q;
  logic [15:0]         maxpf_q;
  logic [15:0]         ceil_q;
  logic [31:0]         last_lba_q;
  logic                bvalid_q;
  logic [1:0]          bresp_q;
  logic                rvalid_q;
  logic [31:0]         rdata_q;
  logic [1:0]          rresp_q;
  logic                wr_fire;
  logic                rd_fire;
  logic                wr_ok;
  logic                rd_ok;
  logic [31:0]         rd_word;
  logic [31:0]         wmask;
  logic                clr_defer;
  rpc_pkg::rpc_state_t state_q;
  logic [31:0]         min_raw;
  logic [31:0]         max_cnt;
  logic [31:0]         min_q;
  logic [31:0]         max_q;
  logic                no_early_q;
  logic [31:0]         count_q;
  logic                skip_q;
  logic                defer_q;
  logic                skip_now;
  logic [31:0]         start_lba;
  logic                fatal;
  logic [31:0]         cnt_d;
  logic [31:0]         lba_d;
  logic                stop_d;
  rpc_pkg::rpc_ret_t   rret_dec;
  rpc_pkg::rpc_ret_t   wret_dec;

  // reset release through two flops; the first feeds only the second
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // write address and data are taken together; one response at a time
  assign wr_fire       = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready  = wr_fire;
  assign rd_fire       = s_axi_arvalid && !rvalid_q;
  assign s_axi_arready = rd_fire;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                  {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

  // write decode; status and limits are read-only except the clear bit
  always_comb
  begin
    wr_ok = 1'b1;
    if (s_axi_awaddr == `RPC_OFF_CFG)
      wr_ok = 1'b1;
    else if (s_axi_awaddr == `RPC_OFF_THRESH)
      wr_ok = 1'b1;
    else if (s_axi_awaddr == `RPC_OFF_MINPF)
      wr_ok = 1'b1;
    else if (s_axi_awaddr == `RPC_OFF_MAXPF)
      wr_ok = 1'b1;
    else if (s_axi_awaddr == `RPC_OFF_CEIL)
      wr_ok = 1'b1;
    else if (s_axi_awaddr == `RPC_OFF_LAST_LBA)
      wr_ok = 1'b1;
    else if (s_axi_awaddr == `RPC_OFF_STATUS)
      wr_ok = 1'b1;
    else
      wr_ok = 1'b0;
  end

  // settings registers; byte strobes honoured
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_q      <= `RPC_RST_CFG;
      thresh_q   <= `RPC_RST_THRESH;
      minpf_q    <= `RPC_RST_MINPF;
      maxpf_q    <= `RPC_RST_MAXPF;
      ceil_q     <= `RPC_RST_CEIL;
      last_lba_q <= `RPC_RST_LAST_LBA;
    end
    else if (wr_fire)
    begin
      if (s_axi_awaddr == `RPC_OFF_CFG)
        cfg_q <= ((cfg_q & ~wmask) | (s_axi_wdata & wmask)) & `RPC_CFG_MASK;
      else if (s_axi_awaddr == `RPC_OFF_THRESH)
        thresh_q <= (thresh_q & ~wmask[15:0]) | (s_axi_wdata[15:0] & wmask[15:0]);
      else if (s_axi_awaddr == `RPC_OFF_MINPF)
        minpf_q <= (minpf_q & ~wmask[15:0]) | (s_axi_wdata[15:0] & wmask[15:0]);
      else if (s_axi_awaddr == `RPC_OFF_MAXPF)
        maxpf_q <= (maxpf_q & ~wmask[15:0]) | (s_axi_wdata[15:0] & wmask[15:0]);
      else if (s_axi_awaddr == `RPC_OFF_CEIL)
        ceil_q <= (ceil_q & ~wmask[15:0]) | (s_axi_wdata[15:0] & wmask[15:0]);
      else if (s_axi_awaddr == `RPC_OFF_LAST_LBA)
        last_lba_q <= (last_lba_q & ~wmask) | (s_axi_wdata & wmask);
    end
  end

  // write response; unmapped offsets answer slverr
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= `RPC_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_ok ? `RPC_RESP_OKAY : `RPC_RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_q <= 1'b0;
  end

  // read decode; unmapped reads return zero with slverr
  always_comb
  begin
    rd_ok   = 1'b1;
    rd_word = 32'h0000_0000;
    if (s_axi_araddr == `RPC_OFF_CFG)
      rd_word = cfg_q;
    else if (s_axi_araddr == `RPC_OFF_THRESH)
      rd_word = {16'h0000, thresh_q};
    else if (s_axi_araddr == `RPC_OFF_MINPF)
      rd_word = {16'h0000, minpf_q};
    else if (s_axi_araddr == `RPC_OFF_MAXPF)
      rd_word = {16'h0000, maxpf_q};
    else if (s_axi_araddr == `RPC_OFF_CEIL)
      rd_word = {16'h0000, ceil_q};
    else if (s_axi_araddr == `RPC_OFF_LAST_LBA)
      rd_word = last_lba_q;
    else if (s_axi_araddr == `RPC_OFF_STATUS)
      rd_word = {count_q[15:0], 13'h0000, defer_q, skip_q, state_q == rpc_pkg::RPC_RUN};
    else if (s_axi_araddr == `RPC_OFF_LIMITS)
      rd_word = {max_q[15:0], min_q[15:0]};
    else
      rd_ok = 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `RPC_RESP_OKAY;
    end
    else if (rd_fire)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= rd_ok ? `RPC_RESP_OKAY : `RPC_RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end

  // counts worked out from the read now arriving
  rpc_scale u_min (
    .scale_mode  (cfg_q[`RPC_CFG_SCALE_BIT]),
    .field       (minpf_q),
    .xfer_len    (rd_cmd_len),
    .ceiling     (ceil_q),
    .use_ceiling (1'b0),
    .blocks      (min_raw)
  );
  rpc_scale u_max (
    .scale_mode  (cfg_q[`RPC_CFG_SCALE_BIT]),
    .field       (maxpf_q),
    .xfer_len    (rd_cmd_len),
    .ceiling     (ceil_q),
    .use_ceiling (1'b1),
    .blocks      (max_cnt)
  );
  rpc_retain u_rret (
    .code      (cfg_q[`RPC_CFG_RRET_LSB +: 4]),
    .ret_class (rret_dec)
  );
  rpc_retain u_wret (
    .code      (cfg_q[`RPC_CFG_WRET_LSB +: 4]),
    .ret_class (wret_dec)
  );

  assign skip_now  = (thresh_q == 16'h0000) || (rd_cmd_len > thresh_q); // R04 R05
  assign start_lba = rd_cmd_lba + {16'h0000, rd_cmd_len}; // R07
  assign fatal     = pf_err && pf_err_fatal;
  assign cnt_d     = count_q + {31'h0000_0000, pf_req_ready};
  assign lba_d     = pf_req_lba + {31'h0000_0000, pf_req_ready};

  // stop on max, medium end, fatal error, or a waiting command past the minimum
  always_comb
  begin
    stop_d = fatal || (cnt_d >= max_q) || (lba_d >= last_lba_q); // R12 R08
    if (cmd_pending && !no_early_q && (cnt_d > min_q))
      stop_d = 1'b1; // R10 R11
  end

  // a new read always restarts the decision, so the latest read governs
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q    <= rpc_pkg::RPC_IDLE;
      count_q    <= 32'h0000_0000;
      pf_req_lba <= 32'h0000_0000;
      min_q      <= 32'h0000_0000;
      max_q      <= 32'h0000_0000;
      no_early_q <= 1'b0;
      skip_q     <= 1'b0;
    end
    else if (rd_cmd_valid)
    begin
      // a minimum above the maximum cannot be met; it is quietly clamped
      min_q      <= (min_raw > max_cnt) ? max_cnt : min_raw; // R06 R03
      max_q      <= max_cnt; // R12 R16
      no_early_q <= (minpf_q == maxpf_q); // R11
      skip_q     <= skip_now;
      count_q    <= 32'h0000_0000;
      pf_req_lba <= start_lba;
      if (!skip_now && (max_cnt != 32'h0000_0000) && (start_lba < last_lba_q))
        state_q <= rpc_pkg::RPC_RUN; // R02 R04
      else
        state_q <= rpc_pkg::RPC_IDLE;
    end
    else
    begin
      case (state_q)
        rpc_pkg::RPC_RUN:
        begin
          count_q    <= cnt_d;
          pf_req_lba <= lba_d;
          if (stop_d)
            state_q <= rpc_pkg::RPC_IDLE;
        end
        default:
          state_q <= rpc_pkg::RPC_IDLE;
      endcase
    end
  end

  assign pf_req_valid = (state_q == rpc_pkg::RPC_RUN);

  // set wins over software clear; non-fatal errors leave no trace
  assign clr_defer = wr_fire && (s_axi_awaddr == `RPC_OFF_STATUS) && s_axi_wstrb[0]
                     && s_axi_wdata[`RPC_ST_DEFER_BIT];
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      defer_q <= 1'b0;
    else if (fatal && pf_req_valid)
      defer_q <= 1'b1; // R09
    else if (clr_defer)
      defer_q <= 1'b0;
  end
  assign deferred_err = defer_q;

  // retention classes follow the settings in force at the last read
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      read_ret_class  <= rpc_pkg::RPC_RET_NONE;
      write_ret_class <= rpc_pkg::RPC_RET_NONE;
    end
    else if (rd_cmd_valid)
    begin
      read_ret_class  <= rret_dec; // R16
      write_ret_class <= wret_dec; // R01
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_accept;
    rd_cmd_valid && !skip_now && (max_cnt != 32'h0000_0000) && (start_lba < last_lba_q);
  endsequence

  a_skip_long: assert property (rd_cmd_valid && (rd_cmd_len > thresh_q) |=> !pf_req_valid) // R04
    else $error("prefetch ran on a read longer than threshold");
  a_zero_thresh: assert property (rd_cmd_valid && (thresh_q == 16'h0000) |=> skip_q && !pf_req_valid) // R05
    else $error("prefetch ran with zero threshold");
  a_start_next: assert property (s_accept |=> pf_req_valid && (pf_req_lba == $past(start_lba))) // R07
    else $error("prefetch start block wrong");
  a_before_end: assert property (pf_req_valid |-> pf_req_lba < last_lba_q) // R08
    else $error("prefetch reached medium end");
  a_max_bound: assert property (count_q <= max_q) // R12
    else $error("prefetch exceeded maximum");
  a_ceil_trunc: assert property (rd_cmd_valid |=> max_q <= {16'h0000, $past(ceil_q)}) // R13
    else $error("maximum not truncated to ceiling");
  a_min_kept: assert property (pf_req_valid && !rd_cmd_valid && !fatal && !pf_req_ready
    && (count_q <= min_q) |=> pf_req_valid) // R06
    else $error("prefetch dropped below minimum");
  a_early_stop: assert property (pf_req_valid && !rd_cmd_valid && cmd_pending && !no_early_q
    && (cnt_d > min_q) |=> !pf_req_valid ##1 !pf_req_valid) // R10
    else $error("prefetch not abandoned for waiting command");
  a_err_defer: assert property (pf_req_valid && fatal |=> deferred_err && !pf_req_valid) // R09
    else $error("fatal prefetch error not deferred");
endmodule
`default_nettype wire

// file: rpc_fetch_model.sv
// far-side fetch engine model: takes prefetch block requests and injects errors
`timescale 1ns/1ps
`default_nettype none
module rpc_fetch_model (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        slow,
  input  wire logic        clr,
  input  wire logic [1:0]  err_go,
  input  wire logic        pf_req_valid,
  input  wire logic [31:0] pf_req_lba,
  output logic             pf_req_ready,
  output logic             pf_err,
  output logic             pf_err_fatal,
  output logic [31:0]      taken,
  output logic [31:0]      first_lba,
  output logic [31:0]      last_lba
);
  // slow mode takes a block every other cycle, so a request must stand while ready is low
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pf_req_ready <= 1'b0;
      pf_err       <= 1'b0;
      pf_err_fatal <= 1'b0;
      taken        <= 32'h0;
      first_lba    <= 32'h0;
      last_lba     <= 32'h0;
    end
    else
    begin
      pf_req_ready <= slow ? ~pf_req_ready : 1'b1;
      pf_err       <= err_go[0] & pf_req_valid;  // errors only while a fetch stands
      pf_err_fatal <= err_go[1] & pf_req_valid;
      if (clr)
        taken <= 32'h0;
      else if (pf_req_valid && pf_req_ready)
      begin
        taken    <= taken + 32'h1;
        last_lba <= pf_req_lba;
        if (taken == 32'h0)
          first_lba <= pf_req_lba;
      end
    end
  end
endmodule
`default_nettype wire

// file: read_prefetch_cache_control_tb.sv
// self-checking bench for the read prefetch cache control block
`timescale 1ns/1ps
`default_nettype none
`include "rpc_map.svh"
module read_prefetch_cache_control_tb;
  logic        sys_clk = 1'b0, reset_n = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, rd_cmd_lba = 32'h0, pf_req_lba, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, rd_cmd_valid = 1'b0;
  logic [15:0] rd_cmd_len = 16'h0;
  logic        cmd_pending = 1'b0, slow = 1'b0, clr = 1'b0;
  logic [1:0]  err_go = 2'b00, s_axi_bresp, s_axi_rresp, pr = 2'h0, pw = 2'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        pf_req_valid, pf_req_ready, pf_err, pf_err_fatal, deferred_err;
  logic [31:0] taken, first_lba, last_lba, rv;
  rpc_pkg::rpc_ret_t read_ret_class, write_ret_class;
  int          bad_count = 0, compares = 0;

  rpc_top dut (.sys_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .rd_cmd_valid, .rd_cmd_lba, .rd_cmd_len, .cmd_pending, .pf_req_valid,
    .pf_req_lba, .pf_req_ready, .pf_err, .pf_err_fatal, .deferred_err, .read_ret_class,
    .write_ret_class);
  rpc_fetch_model fetch (.sys_clk, .reset_n, .slow, .clr, .err_go, .pf_req_valid, .pf_req_lba,
    .pf_req_ready, .pf_err, .pf_err_fatal, .taken, .first_lba, .last_lba);

  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [1:0] cls(input logic [3:0] c);
    return (c == 4'h0) ? 2'h0 : (c == 4'h1) ? 2'h1 : (c == 4'hf) ? 2'h2 : 2'h3;
  endfunction

  // both channels offered together; each released at the edge it is taken
  // no local limit: only the watchdog may end a wait for the answer
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({31'h0, s_axi_bvalid}, 32'h1);
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    chk({31'h0, s_axi_rvalid}, 32'h1);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  // one read command; cnt of all ones means the block count is not judged
  task automatic run_rd(input logic [31:0] lba, input logic [15:0] len, input logic [31:0] cnt,
                        input logic [1:0] go);
    @(posedge sys_clk);
    rd_cmd_valid <= 1'b1;
    rd_cmd_lba <= lba;
    rd_cmd_len <= len;
    clr <= 1'b1;
    @(posedge sys_clk);
    rd_cmd_valid <= 1'b0;
    clr <= 1'b0;
    err_go <= go;
    // a fetch that never ends is caught by the watchdog
    do
    begin
      @(posedge sys_clk);
      err_go <= 2'b00;
    end
    while (pf_req_valid === 1'b1);
    @(posedge sys_clk);
    if (cnt !== 32'hffff_ffff) chk(taken, cnt);
    if (cnt !== 32'hffff_ffff && cnt != 0)
    begin
      chk(first_lba, lba + len);
      chk(last_lba, lba + len + cnt - 1);
    end
  endtask

  task automatic t_regs;
    axi_rd(`RPC_OFF_CFG, rv, `RPC_RESP_OKAY);
    chk(rv, `RPC_RST_CFG);
    axi_rd(`RPC_OFF_THRESH, rv, `RPC_RESP_OKAY);
    chk(rv, {16'h0, `RPC_RST_THRESH});
    axi_rd(`RPC_OFF_MAXPF, rv, `RPC_RESP_OKAY);
    chk(rv, {16'h0, `RPC_RST_MAXPF});
    axi_rd(`RPC_OFF_LAST_LBA, rv, `RPC_RESP_OKAY);
    chk(rv, `RPC_RST_LAST_LBA);
    axi_rd(8'h20, rv, `RPC_RESP_SLVERR);
    chk(rv, 32'h0);
    axi_wr(8'h24, 32'h1234_5678, `RPC_RESP_SLVERR);
  endtask

  task automatic t_basic;
    axi_wr(`RPC_OFF_THRESH, 32'h8, `RPC_RESP_OKAY);
    axi_wr(`RPC_OFF_MINPF, 32'h1, `RPC_RESP_OKAY);
    axi_wr(`RPC_OFF_MAXPF, 32'h3, `RPC_RESP_OKAY);
    slow <= 1'b1;
    run_rd(32'd10, 16'd2, 32'd3, 2'b00);
    slow <= 1'b0;
    axi_rd(`RPC_OFF_STATUS, rv, `RPC_RESP_OKAY);
    chk(rv, 32'h0003_0000);
    run_rd(32'd10, 16'd8, 32'd3, 2'b00);
  endtask

  task automatic t_skip;
    run_rd(32'd10, 16'd9, 32'd0, 2'b00);
    axi_rd(`RPC_OFF_STATUS, rv, `RPC_RESP_OKAY);
    chk({31'h0, rv[`RPC_ST_SKIP_BIT]}, 32'h1);
    axi_wr(`RPC_OFF_THRESH, 32'h0, `RPC_RESP_OKAY);
    run_rd(32'd10, 16'd0, 32'd0, 2'b00);
    run_rd(32'd10, 16'd1, 32'd0, 2'b00);
    axi_wr(`RPC_OFF_THRESH, 32'h8, `RPC_RESP_OKAY);
  endtask

  // a waiting command cuts the fetch once the minimum is passed, unless min equals max
  task automatic t_early;
    cmd_pending <= 1'b1;
    run_rd(32'd20, 16'd2, 32'd2, 2'b00);
    axi_wr(`RPC_OFF_MINPF, 32'h3, `RPC_RESP_OKAY);
    run_rd(32'd20, 16'd2, 32'd3, 2'b00);
    axi_wr(`RPC_OFF_MINPF, 32'h1, `RPC_RESP_OKAY);
    cmd_pending <= 1'b0;
    axi_wr(`RPC_OFF_LAST_LBA, 32'd14, `RPC_RESP_OKAY);
    run_rd(32'd10, 16'd2, 32'd2, 2'b00);
    axi_wr(`RPC_OFF_LAST_LBA, 32'hffff_ffff, `RPC_RESP_OKAY);
  endtask

  task automatic t_scale;
    axi_wr(`RPC_OFF_CFG, 32'h1, `RPC_RESP_OKAY);
    axi_wr(`RPC_OFF_MAXPF, 32'h2, `RPC_RESP_OKAY);
    axi_wr(`RPC_OFF_CEIL, 32'h3, `RPC_RESP_OKAY);
    run_rd(32'd100, 16'd2, 32'd3, 2'b00);
    axi_rd(`RPC_OFF_LIMITS, rv, `RPC_RESP_OKAY);
    chk(rv, 32'h0003_0002);
    axi_wr(`RPC_OFF_CFG, 32'h0, `RPC_RESP_OKAY);
    axi_wr(`RPC_OFF_CEIL, 32'hffff, `RPC_RESP_OKAY);
    axi_wr(`RPC_OFF_MAXPF, 32'h3, `RPC_RESP_OKAY);
  endtask

  task automatic t_err;
    run_rd(32'd10, 16'd2, 32'd3, 2'b01);
    chk({31'h0, deferred_err}, 32'h0);
    run_rd(32'd10, 16'd2, 32'hffff_ffff, 2'b11);
    chk({31'h0, deferred_err}, 32'h1);
    axi_rd(`RPC_OFF_STATUS, rv, `RPC_RESP_OKAY);
    chk({31'h0, rv[`RPC_ST_DEFER_BIT]}, 32'h1);
    axi_wr(`RPC_OFF_STATUS, 32'h4, `RPC_RESP_OKAY);
    chk({31'h0, deferred_err}, 32'h0);
  endtask

  // classes only move at a read, so a config write alone leaves them alone
  task automatic t_ret;
    logic [3:0] codes [4];
    logic [3:0] cw;
    codes = '{4'h0, 4'h1, 4'hf, 4'h5};
    for (int i = 0; i < 4; i++)
    begin
      cw = codes[(i + 1) % 4];
      axi_wr(`RPC_OFF_CFG, {20'h0, cw, codes[i], 4'h0}, `RPC_RESP_OKAY);
      chk({30'h0, read_ret_class}, {30'h0, pr});
      run_rd(32'd10, 16'd2, 32'hffff_ffff, 2'b00);
      pr = cls(codes[i]);
      pw = cls(cw);
      chk({30'h0, read_ret_class}, {30'h0, pr});
      chk({30'h0, write_ret_class}, {30'h0, pw});
    end
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // main sequence: reset held for 8 cycles, then the scenarios
  initial
  begin
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_regs;
    t_basic;
    t_skip;
    t_early;
    t_scale;
    t_err;
    t_ret;
    wrap_up;
  end

  // watchdog well beyond the few hundred cycles the scenarios need
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    wrap_up;
  end
endmodule
`default_nettype wire
